//--- logic/vm_task_pkg.sv
// Constants and types for the legacy task mode control block
package vm_task_pkg;
  // ----------------------------------------
  // Processor flags register layout
  // ----------------------------------------
  localparam int unsigned VM_BIT    = 17;
  localparam int unsigned IO_PRIVILEGE_LEVEL_LO   = 12;
  localparam logic [31:0] FLAGS_RST = 32'h0000_0002;
  localparam logic [31:0] LOW_WORD  = 32'h0000_ffff;
  localparam logic [1:0]  PL_USER   = 2'h3;
  localparam logic [1:0]  PL_KERNEL = 2'h0;
  // ----------------------------------------
  // Vector numbers
  // ----------------------------------------
  localparam logic [7:0] VEC_RSV9  = 8'h09;
  localparam logic [7:0] VEC_TASK  = 8'h0a;
  localparam logic [7:0] VEC_ABSNT = 8'h0b;
  localparam logic [7:0] VEC_GP    = 8'h0d;
  localparam logic [7:0] VEC_RSV15 = 8'h0f;
  localparam logic [7:0] VEC_RSVLO = 8'h13;
  localparam logic [7:0] VEC_RSVHI = 8'h1f;
  localparam logic [7:0] VEC_UD    = 8'h06;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_FLAGS  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_LIN    = 8'h0c;
  localparam logic [7:0] OFS_BASE   = 8'h10;
  // STATUS fields
  localparam int unsigned ST_DROP = 2;
  localparam int unsigned ST_GP   = 3;
  localparam int unsigned ST_UD   = 4;
  localparam int unsigned ST_GEN  = 5;
  localparam int unsigned ST_VLO  = 8;
  // ----------------------------------------
  // Modes and instruction classes
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_REAL   = 2'b00,
    MODE_PROT   = 2'b01,
    MODE_LEGACY = 2'b10
  } mode_t;
  typedef enum logic [3:0] {
    IC_PLAIN  = 4'b0000,
    IC_IFLAG  = 4'b0001,
    IC_PUSHF  = 4'b0010,
    IC_POPF   = 4'b0011,
    IC_SWINT  = 4'b0100,
    IC_INTERRUPT_RETURN_INSTRUCTION   = 4'b0101,
    IC_PORTIO = 4'b0110,
    IC_HALT   = 4'b0111,
    IC_PMONLY = 4'b1000
  } iclass_t;
  // ----------------------------------------
  // Block state, apart from the cached mode and privilege flops
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] flags;
    logic        pe;
    logic [31:0] segBase;
    logic [31:0] linAddr;
    logic        vecValid;
    logic [7:0]  vecOut;
    logic        vecGeneral;
    logic        gpFault;
    logic        udFault;
    logic        dropped;
    logic [7:0]  lastVec;
    logic        initMeta;
    logic        initSync;
    logic        initPrev;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } state_t;
endpackage

//--- logic/legacy_task_mode_control.sv
// Legacy 16-bit task mode control with APB register access
//
// Behaviour
// - Vectors 10 and 11 may be raised in legacy mode, never in real mode.
// - Vectors 9, 15, 19-31 are never raised in legacy or real mode.
// - Vector 13 means segment overrun in real mode, general fault else.
// - Legacy mode is active exactly while the mode flag is one; a switch or return in the cycle protection drops can leave it set in real mode.
// - Mode flag is set only by a task switch or interrupt return.
// - Flag-pop writes cannot change the mode flag.
// - Segment loads use descriptor base in protected mode, shift-by-four base else.
// - Decode uses the mode flag for unsupported and IO_PRIVILEGE_LEVEL-checked opcodes.
// - Legacy mode runs all permission checks at privilege level 3.
// - A 16-bit task segment never loads the upper flags word.
// - 20-bit legacy addresses are zero-extended to 32 bits, never wrapped.
// - Legacy mode faults flag, push/pop, soft int, return when IO_PRIVILEGE_LEVEL < 3.
// - Reset or init pin leaves legacy mode and enters real mode.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module legacy_task_mode_control (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Init pin from outside the clock domain
  input  wire logic        initPin,
  // Core events, same clock
  input  wire logic        taskSwitchReq,
  input  wire logic        newTss32,
  input  wire logic [31:0] taskFlagsImage,
  input  wire logic        iretReq,
  input  wire logic [31:0] iretFlagsImage,
  input  wire logic        flagPopReq,
  input  wire logic [31:0] flagPopValue,
  input  wire logic        segLoadReq,
  input  wire logic [15:0] segSelector,
  input  wire logic [31:0] descBase,
  input  wire logic        addrReq,
  input  wire logic [31:0] addrOffset,
  input  wire logic        decodeReq,
  input  wire logic [3:0]  instrClass,
  input  wire logic [1:0]  descPrivLevel,
  input  wire logic        excReq,
  input  wire logic [7:0]  excVector,
  // Status towards the core
  output logic             vmFlag,
  output logic [1:0]       modeOut,
  output logic [1:0]       curPrivLevel,
  output logic [31:0]      segBase,
  output logic [31:0]      linearAddr,
  output logic             vecValid,
  output logic [7:0]       vecOut,
  output logic             vecGeneral,
  output logic             gpFault,
  output logic             udFault
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Mode from the flags and protection enable
  function automatic vm_task_pkg::mode_t modeOf(
    input logic [31:0] f,
    input logic        p
  );
    if (!p) begin
      modeOf = vm_task_pkg::MODE_REAL;
    end else if (f[vm_task_pkg::VM_BIT]) begin
      modeOf = vm_task_pkg::MODE_LEGACY;
    end else begin
      modeOf = vm_task_pkg::MODE_PROT;
    end
  endfunction

  function automatic logic [1:0] ioplOf(input logic [31:0] f);
    ioplOf = f[vm_task_pkg::IO_PRIVILEGE_LEVEL_LO +: 2];
  endfunction

  // Effective privilege level used for every permission check
  function automatic logic [1:0] privOf(
    input logic [31:0] f,
    input logic        p,
    input logic [1:0]  d
  );
    if (modeOf(f, p) == vm_task_pkg::MODE_LEGACY) begin
      privOf = vm_task_pkg::PL_USER;
    end else if (!p) begin
      privOf = vm_task_pkg::PL_KERNEL;
    end else begin
      privOf = d;
    end
  endfunction

  // Vectors that may leave the block in a given mode
  function automatic logic vecAllowed(
    input logic [7:0]          v,
    input vm_task_pkg::mode_t  m
  );
    logic rsv;
    rsv = (v == vm_task_pkg::VEC_RSV9) || (v == vm_task_pkg::VEC_RSV15)
       || (v >= vm_task_pkg::VEC_RSVLO && v <= vm_task_pkg::VEC_RSVHI);
    if (m == vm_task_pkg::MODE_PROT) begin
      vecAllowed = 1'b1;
    end else if (rsv) begin
      vecAllowed = 1'b0;
    end else if (v == vm_task_pkg::VEC_TASK || v == vm_task_pkg::VEC_ABSNT) begin
      vecAllowed = (m == vm_task_pkg::MODE_LEGACY);
    end else begin
      vecAllowed = 1'b1;
    end
  endfunction

  // Mapped register check
  function automatic logic isMapped(input logic [7:0] a);
    if (a == vm_task_pkg::OFS_CTRL) begin
      isMapped = 1'b1;
    end else if (a == vm_task_pkg::OFS_FLAGS) begin
      isMapped = 1'b1;
    end else if (a == vm_task_pkg::OFS_STATUS) begin
      isMapped = 1'b1;
    end else if (a == vm_task_pkg::OFS_LIN) begin
      isMapped = 1'b1;
    end else if (a == vm_task_pkg::OFS_BASE) begin
      isMapped = 1'b1;
    end else begin
      isMapped = 1'b0;
    end
  endfunction

  // Flag-pop value merge: mode flag always keeps its old value
  function automatic logic [31:0] popMerge(
    input logic [31:0] oldF,
    input logic [31:0] newF
  );
    popMerge = newF;
    popMerge[vm_task_pkg::VM_BIT] = oldF[vm_task_pkg::VM_BIT];
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  vm_task_pkg::state_t s_r;
  vm_task_pkg::state_t s_nxt;
  vm_task_pkg::mode_t  mode;
  logic [1:0]          io_privilege_level;
  logic [1:0]          current_privilege_level;
  logic                apbAcc;
  logic                ioplLow;
  logic [31:0]         rdVal;
  logic [31:0]         statusVal;

  assign mode    = modeOf(s_r.flags, s_r.pe);
  assign io_privilege_level    = ioplOf(s_r.flags);
  assign current_privilege_level     = privOf(s_r.flags, s_r.pe, descPrivLevel);
  assign apbAcc  = psel & penable;
  assign ioplLow = (io_privilege_level != vm_task_pkg::PL_USER);

  // Status word as seen by software
  always_comb begin
    statusVal = '0;
    statusVal[1:0] = mode;
    statusVal[vm_task_pkg::ST_DROP] = s_r.dropped;
    statusVal[vm_task_pkg::ST_GP]   = s_r.gpFault;
    statusVal[vm_task_pkg::ST_UD]   = s_r.udFault;
    statusVal[vm_task_pkg::ST_GEN]  = s_r.vecGeneral;
    statusVal[vm_task_pkg::ST_VLO +: 8] = s_r.lastVec;
  end

  // Read data decode; unmapped reads return zero
  always_comb begin
    if (paddr == vm_task_pkg::OFS_CTRL) begin
      rdVal = {31'h0, s_r.pe};
    end else if (paddr == vm_task_pkg::OFS_FLAGS) begin
      rdVal = s_r.flags;
    end else if (paddr == vm_task_pkg::OFS_STATUS) begin
      rdVal = statusVal;
    end else if (paddr == vm_task_pkg::OFS_LIN) begin
      rdVal = s_r.linAddr;
    end else if (paddr == vm_task_pkg::OFS_BASE) begin
      rdVal = s_r.segBase;
    end else begin
      rdVal = '0;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.vecValid = 1'b0;
    s_nxt.gpFault  = 1'b0;
    s_nxt.udFault  = 1'b0;
    s_nxt.pready   = 1'b0;
    s_nxt.pslverr  = 1'b0;
    // Init pin synchroniser; the edge is taken from the second and third stages
    s_nxt.initMeta = initPin;
    s_nxt.initSync = s_r.initMeta;
    s_nxt.initPrev = s_r.initSync;

    // APB: one wait state, answer registered
    if (apbAcc && !s_r.pready) begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = !isMapped(paddr);
      s_nxt.prdata  = rdVal;
    end
    if (apbAcc && s_r.pready && pwrite && !s_r.pslverr) begin
      if (paddr == vm_task_pkg::OFS_CTRL) begin
        s_nxt.pe = pwdata[0];
        // Dropping protection also drops the legacy mode
        if (!pwdata[0]) begin
          s_nxt.flags[vm_task_pkg::VM_BIT] = 1'b0;
        end
      end else if (paddr == vm_task_pkg::OFS_FLAGS) begin
        s_nxt.flags = popMerge(s_r.flags, pwdata);
      end else if (paddr == vm_task_pkg::OFS_STATUS) begin
        if (pwdata[vm_task_pkg::ST_DROP]) begin
          s_nxt.dropped = 1'b0;
        end
      end
    end

    // Flag-pop from the core; in legacy mode it is IO_PRIVILEGE_LEVEL sensitive
    if (flagPopReq) begin
      if (mode == vm_task_pkg::MODE_LEGACY && ioplLow) begin
        s_nxt.gpFault = 1'b1;
      end else begin
        s_nxt.flags = popMerge(s_r.flags, flagPopValue);
      end
    end

    // Interrupt return: only path besides a task switch that sets the flag
    if (iretReq) begin
      if (mode == vm_task_pkg::MODE_LEGACY) begin
        if (ioplLow) begin
          s_nxt.gpFault = 1'b1;
        end else begin
          s_nxt.flags = popMerge(s_r.flags, iretFlagsImage);
        end
      end else if (mode == vm_task_pkg::MODE_PROT
                   && current_privilege_level == vm_task_pkg::PL_KERNEL) begin
        s_nxt.flags = iretFlagsImage;
      end else begin
        s_nxt.flags = popMerge(s_r.flags, iretFlagsImage);
      end
    end

    // Task switch loads the image; a 16-bit segment has no upper word
    if (taskSwitchReq && s_r.pe) begin
      if (newTss32) begin
        s_nxt.flags = taskFlagsImage;
      end else begin
        s_nxt.flags = taskFlagsImage & vm_task_pkg::LOW_WORD;
      end
    end

    // Segment base uses the flag as updated by a same-cycle switch
    if (segLoadReq) begin
      if (modeOf(s_nxt.flags, s_nxt.pe) == vm_task_pkg::MODE_PROT) begin
        s_nxt.segBase = descBase;
      end else begin
        s_nxt.segBase = {12'h000, segSelector, 4'h0};
      end
    end

    // Linear address: 16-bit offsets outside protected mode, no wrap
    if (addrReq) begin
      if (mode == vm_task_pkg::MODE_PROT) begin
        s_nxt.linAddr = s_r.segBase + addrOffset;
      end else begin
        // Carry into bit 20 is kept; paging handles any wrap
        s_nxt.linAddr = {11'h000, s_r.segBase[19:0] + {5'h00,
                         addrOffset[15:0]}};
      end
    end

    // Decode checks
    if (decodeReq) begin
      if (mode == vm_task_pkg::MODE_LEGACY) begin
        case (instrClass)
          vm_task_pkg::IC_IFLAG, vm_task_pkg::IC_PUSHF,
          vm_task_pkg::IC_POPF, vm_task_pkg::IC_SWINT,
          vm_task_pkg::IC_INTERRUPT_RETURN_INSTRUCTION: begin
            s_nxt.gpFault = ioplLow;
          end
          vm_task_pkg::IC_HALT: begin
            s_nxt.gpFault = 1'b1;
          end
          vm_task_pkg::IC_PMONLY: begin
            s_nxt.udFault = 1'b1;
          end
          default: begin
            s_nxt.gpFault = 1'b0;
          end
        endcase
      end else if (mode == vm_task_pkg::MODE_PROT) begin
        case (instrClass)
          vm_task_pkg::IC_IFLAG, vm_task_pkg::IC_PORTIO: begin
            s_nxt.gpFault = (current_privilege_level > io_privilege_level);
          end
          vm_task_pkg::IC_HALT: begin
            s_nxt.gpFault = (current_privilege_level != vm_task_pkg::PL_KERNEL);
          end
          default: begin
            s_nxt.gpFault = 1'b0;
          end
        endcase
      end else if (instrClass == vm_task_pkg::IC_PMONLY) begin
        s_nxt.udFault = 1'b1;
      end
    end

    // Vector filter; a drop sets the sticky bit, winning over a clear
    if (excReq) begin
      if (vecAllowed(excVector, mode)) begin
        s_nxt.vecValid   = 1'b1;
        s_nxt.vecOut     = excVector;
        s_nxt.lastVec    = excVector;
        s_nxt.vecGeneral = (excVector == vm_task_pkg::VEC_GP)
                         && (mode != vm_task_pkg::MODE_REAL);
      end else begin
        s_nxt.dropped = 1'b1;
      end
    end

    // Init pin edge overrides flags, protection enable and segment base: back to real mode
    if (s_r.initSync && !s_r.initPrev) begin
      s_nxt.flags   = vm_task_pkg::FLAGS_RST;
      s_nxt.pe      = 1'b0;
      s_nxt.segBase = '0;
    end
  end

  // ----------------------------------------
  // State register; reset lands in real mode
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.flags <= vm_task_pkg::FLAGS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Cached mode and privilege so outputs come from flops
  logic [1:0] modeOut_r;
  logic [1:0] curPriv_r;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      modeOut_r <= vm_task_pkg::MODE_REAL;
      curPriv_r <= vm_task_pkg::PL_KERNEL;
    end else begin
      modeOut_r <= modeOf(s_nxt.flags, s_nxt.pe);
      curPriv_r <= privOf(s_nxt.flags, s_nxt.pe, descPrivLevel);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pready       = s_r.pready;
  assign pslverr      = s_r.pslverr;
  assign prdata       = s_r.prdata;
  assign vmFlag       = s_r.flags[vm_task_pkg::VM_BIT];
  assign modeOut      = modeOut_r;
  assign curPrivLevel = curPriv_r;
  assign segBase      = s_r.segBase;
  assign linearAddr   = s_r.linAddr;
  assign vecValid     = s_r.vecValid;
  assign vecOut       = s_r.vecOut;
  assign vecGeneral   = s_r.vecGeneral;
  assign gpFault      = s_r.gpFault;
  assign udFault      = s_r.udFault;

endmodule // legacy_task_mode_control

//--- tb/legacy_task_mode_control_properties.sv
// Concurrent property checker for the legacy task mode control block
`timescale 1ns/100ps
module legacy_task_mode_checker (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        initPin,
  input wire logic        taskSwitchReq,
  input wire logic        newTss32,
  input wire logic        iretReq,
  input wire logic        flagPopReq,
  input wire logic        segLoadReq,
  input wire logic [15:0] segSelector,
  input wire logic        addrReq,
  input wire logic [31:0] addrOffset,
  input wire logic        decodeReq,
  input wire logic [3:0]  instrClass,
  input wire logic        excReq,
  input wire logic [7:0]  excVector,
  input wire logic        vmFlag,
  input wire logic [1:0]  modeOut,
  input wire logic [1:0]  curPrivLevel,
  input wire logic [31:0] segBase,
  input wire logic [31:0] linearAddr,
  input wire logic        vecValid,
  input wire logic        vecGeneral,
  input wire logic        gpFault,
  input wire logic        udFault
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Quiet cycle: nothing else may move the mode in the same edge
  logic        quiet;
  logic        rsvd;
  logic [15:0] offLo;
  assign quiet = !psel && !taskSwitchReq && !iretReq && !initPin;
  assign rsvd  = excVector == 8'h09 || excVector == 8'h0f ||
                 (excVector >= 8'h13 && excVector <= 8'h1f);
  assign offLo = addrOffset[15:0];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Init acts after the synchroniser, so allow a short window
  sequence s_real_again;
    ##[1:4] (modeOut == vm_task_pkg::MODE_REAL && !vmFlag);
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_vm_mode_match: assert property (
    vmFlag == (modeOut == vm_task_pkg::MODE_LEGACY))
    else $error("mode output disagrees with flag");
  a_legacy_cpl_three: assert property (
    vmFlag |-> curPrivLevel == vm_task_pkg::PL_USER)
    else $error("privilege not 3 in legacy mode");
  a_vm_rise_cause: assert property (
    $rose(vmFlag) |-> $past(iretReq || (taskSwitchReq && newTss32)))
    else $error("flag set without a legal cause");
  a_pop_keeps_vm: assert property (
    flagPopReq && !iretReq && !taskSwitchReq |=> !$rose(vmFlag))
    else $error("flag pop set the mode flag");
  a_no_rsvd_vec: assert property (
    excReq && quiet && rsvd && modeOut != vm_task_pkg::MODE_PROT
    |=> !vecValid)
    else $error("reserved vector raised");
  a_task_vecs: assert property (
    excReq && quiet && (excVector == 8'h0a || excVector == 8'h0b)
    |=> vecValid == ($past(modeOut) != vm_task_pkg::MODE_REAL))
    else $error("vector 10 or 11 wrongly handled");
  a_vec13_meaning: assert property (
    excReq && quiet && excVector == 8'h0d
    |=> vecValid && vecGeneral == ($past(modeOut) != 2'b00))
    else $error("vector 13 meaning wrong");
  a_legacy_seg_base: assert property (
    segLoadReq && quiet && vmFlag
    |=> segBase == {12'h000, $past(segSelector), 4'h0})
    else $error("legacy segment base not shifted");
  a_addr_extend: assert property (
    addrReq && quiet && !segLoadReq && vmFlag
    |=> linearAddr == $past(segBase) + {16'h0000, $past(offLo)})
    else $error("legacy address wrapped or truncated");
  a_legacy_decode: assert property (
    decodeReq && quiet && vmFlag && (instrClass == 4'h7 ||
    instrClass == 4'h8) |=> gpFault == ($past(instrClass) == 4'h7)
    && udFault == ($past(instrClass) == 4'h8))
    else $error("legacy decode fault wrong");
  a_init_real: assert property (
    $rose(initPin) |-> s_real_again)
    else $error("init did not return to real mode");
endmodule // legacy_task_mode_checker

bind legacy_task_mode_control legacy_task_mode_checker i_chk (
  .sys_clk, .rst_b, .psel, .initPin, .taskSwitchReq, .newTss32,
  .iretReq, .flagPopReq, .segLoadReq, .segSelector, .addrReq,
  .addrOffset, .decodeReq, .instrClass, .excReq, .excVector, .vmFlag,
  .modeOut, .curPrivLevel, .segBase, .linearAddr, .vecValid,
  .vecGeneral, .gpFault, .udFault);

//--- tb/legacy_task_mode_control_tb.sv
// Self-checking testbench for the legacy task mode control block
`timescale 1ns/100ps
module legacy_task_mode_control_tb;
  logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic        initPin, taskSwitchReq, newTss32, iretReq, flagPopReq;
  logic        segLoadReq, addrReq, decodeReq, excReq, vmFlag, rdErr;
  logic        vecValid, vecGeneral, gpFault, udFault;
  logic [1:0]  descPrivLevel, modeOut, curPrivLevel;
  logic [3:0]  instrClass;
  logic [7:0]  paddr, excVector, vecOut;
  logic [15:0] segSelector;
  logic [31:0] pwdata, prdata, taskFlagsImage, iretFlagsImage, rd;
  logic [31:0] flagPopValue, descBase, addrOffset, segBase, linearAddr;
  logic [7:0]  rsv [5] = '{8'h09, 8'h0f, 8'h13, 8'h14, 8'h1f};
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;

  legacy_task_mode_control i_dut (.sys_clk, .rst_b, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .initPin,
    .taskSwitchReq, .newTss32, .taskFlagsImage, .iretReq,
    .iretFlagsImage, .flagPopReq, .flagPopValue, .segLoadReq,
    .segSelector, .descBase, .addrReq, .addrOffset, .decodeReq,
    .instrClass, .descPrivLevel, .excReq, .excVector, .vmFlag, .modeOut,
    .curPrivLevel, .segBase, .linearAddr, .vecValid, .vecOut,
    .vecGeneral, .gpFault, .udFault);

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // Ends a one-cycle core request and lets its result settle
  task automatic go();
    @(posedge sys_clk);
    {taskSwitchReq, iretReq, flagPopReq, segLoadReq} <= 4'h0;
    {addrReq, decodeReq, excReq} <= 3'h0;
    #1;
  endtask
  task automatic exc(input logic [7:0] v);
    @(posedge sys_clk);
    excReq <= 1'b1;
    excVector <= v;
    go();
  endtask
  task automatic decode(input logic [3:0] c);
    @(posedge sys_clk);
    decodeReq <= 1'b1;
    instrClass <= c;
    go();
  endtask
  task automatic rsvd_vecs();
    foreach (rsv[i]) begin
      exc(rsv[i]);
      check(vecValid, 0);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_b, psel, penable, pwrite, initPin, newTss32} = 6'h00;
    {taskSwitchReq, iretReq, flagPopReq, segLoadReq} = 4'h0;
    {addrReq, decodeReq, excReq, descPrivLevel, instrClass} = 9'h000;
    {paddr, excVector, segSelector} = 32'h0;
    {pwdata, taskFlagsImage, iretFlagsImage} = 96'h0;
    {flagPopValue, descBase, addrOffset} = 96'h0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    check(modeOut, 0);
    apb(0, vm_task_pkg::OFS_FLAGS, 0);
    check(rd, vm_task_pkg::FLAGS_RST);
    apb(0, 8'h14, 0);
    check(rdErr, 1);
    $display("test reset done");
    // Real mode: task faults and reserved vectors are dropped
    exc(8'h0a);
    check(vecValid, 0);
    exc(8'h0b);
    check(vecValid, 0);
    rsvd_vecs();
    exc(8'h0d);
    check({vecValid, vecGeneral}, 2);
    exc(8'h20);
    check(vecValid, 1);
    apb(0, vm_task_pkg::OFS_STATUS, 0);
    check(rd[2], 1);
    $display("test real done");
    // Protected mode: no path but a legal one may set the flag
    apb(1, vm_task_pkg::OFS_CTRL, 1);
    check(modeOut, 1);
    @(posedge sys_clk);
    taskSwitchReq <= 1'b1;
    taskFlagsImage <= 32'h0002_0002;
    go();
    check(vmFlag, 0);
    @(posedge sys_clk);
    flagPopReq <= 1'b1;
    flagPopValue <= 32'h0002_0002;
    go();
    check(vmFlag, 0);
    apb(1, vm_task_pkg::OFS_FLAGS, 32'h0002_0002);
    apb(0, vm_task_pkg::OFS_FLAGS, 0);
    check(rd[17], 0);
    @(posedge sys_clk);
    segLoadReq <= 1'b1;
    descBase <= 32'h1234_5670;
    go();
    check(segBase, 32'h1234_5670);
    $display("test protected done");
    // Enter legacy mode by interrupt return with IO_PRIVILEGE_LEVEL 0
    @(posedge sys_clk);
    iretReq <= 1'b1; // Monitor at level 0
    iretFlagsImage <= 32'h0002_0002;
    go();
    check({vmFlag, modeOut, curPrivLevel}, 5'h1b);
    apb(0, vm_task_pkg::OFS_FLAGS, 0);
    check(rd[17], 1);
    @(posedge sys_clk);
    segLoadReq <= 1'b1;
    segSelector <= 16'hffff;
    go();
    check(segBase, 32'h000f_fff0);
    @(posedge sys_clk);
    addrReq <= 1'b1;
    addrOffset <= 32'h0000_ffff;
    go();
    // No wrap here: software pages alias it
    check(linearAddr, 32'h0010_ffef);
    exc(8'h0a);
    check({vecValid, vecOut}, 9'h10a);
    exc(8'h0d);
    check({vecValid, vecGeneral}, 3);
    rsvd_vecs();
    for (int i = 1; i <= 5; i++) begin
      decode(4'(i));
      check(gpFault, 1);
    end
    decode(vm_task_pkg::IC_PORTIO);
    check(gpFault, 0);
    decode(vm_task_pkg::IC_HALT);
    check(gpFault, 1);
    decode(vm_task_pkg::IC_PMONLY);
    check(udFault, 1);
    @(posedge sys_clk);
    flagPopReq <= 1'b1;
    flagPopValue <= 32'h0000_3002;
    go();
    check({gpFault, vmFlag}, 3);
    $display("test legacy done");
    // Leave, then re-enter through a 32-bit task switch at IO_PRIVILEGE_LEVEL 3
    apb(1, vm_task_pkg::OFS_CTRL, 0);
    check({modeOut, vmFlag}, 0);
    apb(1, vm_task_pkg::OFS_CTRL, 1);
    @(posedge sys_clk);
    taskSwitchReq <= 1'b1;
    newTss32 <= 1'b1; // 32-bit task segment
    taskFlagsImage <= 32'h0002_3002;
    go();
    check(vmFlag, 1);
    decode(vm_task_pkg::IC_IFLAG);
    check(gpFault, 0);
    $display("test task switch done");
    // Init pin drops back to real mode
    @(posedge sys_clk);
    initPin <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    check({modeOut, vmFlag}, 0);
    check(segBase, 0);
    $display("test init done");
    end_of_test();
  end
endmodule // legacy_task_mode_control_tb
